// >>> hdl/adc_convert_map.vh
// timing counts and frame layout for the converter control block
`ifndef ADC_CONVERT_MAP_VH
`define ADC_CONVERT_MAP_VH
`define CLK_PERIOD_PS      5000
`define CONV_TIME_NS       5000
`define CONV_CYCLES        ((`CONV_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define WAKE_TIME_NS       5000
`define WAKE_CYCLES        ((`WAKE_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define HOLD_TIME_NS       10
`define HOLD_CYCLES        ((`HOLD_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define FRAME_BITS         16
`define RESULT_BITS        14
`define LEAD_ZEROS         2
`endif

// >>> hdl/adc_convert_serial_readout.v
// conversion control and serial readout of a 14-bit converter
// How it works
// - start falling edge holds sample, starts conversion
// - busy high from start fall to done
// - start low at end enters power-down
// - start rising edge wakes from power-down
// - new serial bit on each of the first fifteen serial clock falls
// - frame is two zeros, fourteen result bits
// - after sixteenth fall hold, then release
// - twos complement bipolar, straight binary unipolar
// - conversion 5 us, with wake-up 10 us
`timescale 1ns/1ps
`include "adc_convert_map.vh"
module adc_convert_serial_readout #(
  parameter [31:0] CONV_CYCLES = `CONV_CYCLES,
  parameter [31:0] WAKE_CYCLES = `WAKE_CYCLES
) (
  // clock and reset
  input  wire        mclk_i,
  input  wire        reset_i,
  // conversion control pins
  input  wire        conversion_start_n_i,
  output wire        busy_o,
  output wire        track_hold_o,
  output wire        power_down_o,
  // variant strap: 1 selects bipolar coding
  input  wire        bipolar_i,
  // result from the analog core, straight binary offset code
  input  wire [13:0] sar_code_i,
  // serial port
  input  wire        serial_clk_i,
  output wire        serial_result_out_o,
  output wire        serial_result_out_oe_o
);
  // sequencer states
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_CONV  = 2'h1;
  localparam [1:0] ST_SLEEP = 2'h2;
  localparam [1:0] ST_WAKE  = 2'h3;
  // map constants are plain integers; cut them to counter width here
  localparam integer FRAME_INT  = `FRAME_BITS;
  localparam integer HOLD_INT   = `HOLD_CYCLES;
  localparam [4:0]   FRAME_LAST = FRAME_INT[4:0];
  localparam [3:0]   HOLD_CNT   = HOLD_INT[3:0];

  wire        cs_level;
  wire        cs_rise;
  wire        cs_fall;
  wire        sclk_fall;
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [31:0] cnt_r;
  reg  [31:0] cnt_nxt;
  reg         busy_r;
  reg         hold_r;
  reg  [15:0] shift_r;
  reg  [4:0]  bit_cnt_r;
  reg         dout_r;
  reg         oe_r;
  reg  [3:0]  rel_cnt_r;
  reg         bip_r;
  reg         pend_r;
  wire [13:0] coded;
  wire        start_take;
  wire        conv_done;

  // start pin idles high
  edge_sync #(
    .IDLE_LEVEL (1'b1)
  ) u_cs_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .async_i (conversion_start_n_i),
    .level_o (cs_level),
    .rise_o  (cs_rise),
    .fall_o  (cs_fall)
  );

  // serial clock parks low; a high reset level would fake a fall
  edge_sync #(
    .IDLE_LEVEL (1'b0)
  ) u_sclk_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .async_i (serial_clk_i),
    .level_o (),
    .rise_o  (),
    .fall_o  (sclk_fall)
  );

  // strap caught by a clocked process, never by the reset itself
  always @(posedge mclk_i) begin
    bip_r <= bipolar_i;
  end

  // invert msb turns offset binary into twos complement
  assign coded = bip_r ? {~sar_code_i[13], sar_code_i[12:0]} : sar_code_i;

  // a start fall is taken when idle, or queued while waking up
  assign start_take = cs_fall && (state_r == ST_IDLE || state_r == ST_WAKE);
  assign conv_done  = (state_r == ST_CONV) && (cnt_r == 32'h0);

  // conversion sequencing
  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (cs_fall) begin
          state_nxt = ST_CONV;
          cnt_nxt   = CONV_CYCLES - 32'h1;
        end
      end
      ST_CONV: begin
        if (cnt_r == 32'h0) begin
          state_nxt = cs_level ? ST_IDLE : ST_SLEEP;
        end else begin
          cnt_nxt = cnt_r - 32'h1;
        end
      end
      ST_SLEEP: begin
        // only a rising start edge leaves sleep
        if (cs_rise) begin
          state_nxt = ST_WAKE;
          cnt_nxt   = WAKE_CYCLES - 32'h1;
        end
      end
      ST_WAKE: begin
        // a start fall during wake-up queues the conversion after it
        if (cnt_r == 32'h0) begin
          if (pend_r || cs_fall) begin
            state_nxt = ST_CONV;
            cnt_nxt   = CONV_CYCLES - 32'h1;
          end else begin
            state_nxt = ST_IDLE;
          end
        end else begin
          cnt_nxt = cnt_r - 32'h1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // state, busy and track/hold registers
  always @(posedge mclk_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
      cnt_r   <= 32'h0;
      busy_r  <= 1'b0;
      hold_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      if (start_take) begin
        busy_r <= 1'b1;
        hold_r <= 1'b1;
      end else if (conv_done) begin
        busy_r <= 1'b0;
        hold_r <= 1'b0;
      end
    end
  end

  // remembers a start fall inside wake-up; a narrow start pulse
  // would otherwise be lost while the core powers up
  always @(posedge mclk_i) begin
    if (reset_i) begin
      pend_r <= 1'b0;
    end else if (state_r == ST_WAKE && cs_fall) begin
      pend_r <= 1'b1;
    end else if (state_r != ST_WAKE) begin
      pend_r <= 1'b0;
    end
  end

  // serial shifter; a new frame loads when a conversion ends
  always @(posedge mclk_i) begin
    if (reset_i) begin
      shift_r   <= 16'h0000;
      bit_cnt_r <= 5'h00;
      dout_r    <= 1'b0;
      oe_r      <= 1'b0;
      rel_cnt_r <= 4'h0;
    end else begin
      if (conv_done) begin
        shift_r   <= {{`LEAD_ZEROS{1'b0}}, coded};
        bit_cnt_r <= 5'h00;
        dout_r    <= 1'b0;
        oe_r      <= 1'b1;
        rel_cnt_r <= 4'h0;
      end else if (sclk_fall && bit_cnt_r < FRAME_LAST) begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
        // 16th fall moves no bit: the last one stands for the hold time
        if (bit_cnt_r == FRAME_LAST - 5'h01) begin
          rel_cnt_r <= HOLD_CNT;
        end else begin
          dout_r  <= shift_r[14];
          shift_r <= {shift_r[14:0], 1'b0};
        end
      end else if (rel_cnt_r != 4'h0) begin
        rel_cnt_r <= rel_cnt_r - 4'h1;
        if (rel_cnt_r == 4'h1) begin
          oe_r <= 1'b0;
        end
      end
    end
  end

  // pin drivers; power-down decodes straight from the state register
  assign busy_o                 = busy_r;
  assign track_hold_o           = hold_r;
  assign power_down_o           = (state_r == ST_SLEEP);
  assign serial_result_out_o    = dout_r;
  assign serial_result_out_oe_o = oe_r;
endmodule // adc_convert_serial_readout

// >>> hdl/edge_sync.v
// two-flop synchroniser with rise and fall detection
`timescale 1ns/1ps
module edge_sync #(
  parameter [0:0] IDLE_LEVEL = 1'b1
) (
  // clock and reset
  input  wire mclk_i,
  input  wire reset_i,
  // asynchronous level in
  input  wire async_i,
  // synchronised level and edges
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);
  reg meta_r;
  reg sync_r;
  reg last_r;

  // meta_r is read only by sync_r
  // reset to the pin's idle level, else a false edge follows reset
  always @(posedge mclk_i) begin
    if (reset_i) begin
      meta_r <= IDLE_LEVEL;
      sync_r <= IDLE_LEVEL;
      last_r <= IDLE_LEVEL;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level_o = sync_r;
  assign rise_o  = sync_r & ~last_r;
  assign fall_o  = ~sync_r & last_r;
endmodule // edge_sync

// >>> testbench/adc_readout_assertions.sv
// port assertions for the converter control and readout block
`timescale 1ns/1ps
module adc_readout_checker #(
  parameter [31:0] CONV_CYCLES = 20,
  parameter [31:0] WAKE_CYCLES = 20
) (
  // clock, reset and pins, watched only
  input wire        mclk_i, reset_i, conversion_start_n_i, busy_o, track_hold_o,
  input wire        power_down_o, bipolar_i, serial_clk_i, serial_result_out_o,
  input wire        serial_result_out_oe_o,
  input wire [13:0] sar_code_i
);
  logic [31:0] busy_cnt_r;
  logic [31:0] wake_cnt_r;
  logic        queued_r;
  // length of the busy pulse so far
  always @(posedge mclk_i) busy_cnt_r <= (reset_i || !busy_o) ? 32'h0 : busy_cnt_r + 1;
  // cycles since sleep ended, parked high until the first sleep
  always @(posedge mclk_i) begin
    if (reset_i) wake_cnt_r <= 32'hffff;
    else if (power_down_o) wake_cnt_r <= 32'h0;
    else if (wake_cnt_r != 32'hffff) wake_cnt_r <= wake_cnt_r + 32'h1;
  end
  // a conversion whose start fell inside wake-up runs on from the wake
  always @(posedge mclk_i) begin
    if (reset_i) queued_r <= 1'b0;
    else if (busy_o && busy_cnt_r == 32'h0) queued_r <= (wake_cnt_r <= WAKE_CYCLES);
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  sequence conv_end; $fell(busy_o); endsequence
  sequence plain_end; $fell(busy_o) && !queued_r; endsequence
  sequence queued_end; $fell(busy_o) && queued_r; endsequence
  a_hold_with_busy: assert property (track_hold_o == busy_o)
    else $error("hold differs from busy");
  a_start_to_busy: assert property ($fell(conversion_start_n_i) && !busy_o && !power_down_o
    |-> ##[2:5] $rose(busy_o)) else $error("no conversion after start");
  a_busy_length: assert property (plain_end |-> busy_cnt_r == CONV_CYCLES)
    else $error("busy length wrong");
  a_sleep_conv: assert property (queued_end |-> wake_cnt_r == WAKE_CYCLES + CONV_CYCLES)
    else $error("wake plus conversion time wrong");
  a_sleep_entry: assert property ($fell(busy_o) && !conversion_start_n_i
    && !$past(conversion_start_n_i, 4) |-> power_down_o) else $error("no sleep");
  a_wake_time: assert property ($rose(conversion_start_n_i) && power_down_o
    |-> ##[2:5] $fell(power_down_o)) else $error("wake-up did not begin");
  a_bit_launch: assert property ($changed(serial_result_out_o) && serial_result_out_oe_o
    && $past(serial_result_out_oe_o) |-> !$past(serial_clk_i) && !$past(serial_clk_i, 2))
    else $error("bit moved without clock fall");
  a_frame_load: assert property (conv_end |-> serial_result_out_oe_o && !serial_result_out_o)
    else $error("frame not loaded");
  a_release_hold: assert property ($fell(serial_result_out_oe_o)
    |-> !$past(serial_clk_i, 4) && $past(serial_clk_i, 9)) else $error("release timing");
  a_drive_source: assert property ($rose(serial_result_out_oe_o) |-> conv_end)
    else $error("output driven without result");
endmodule // adc_readout_checker

// >>> testbench/serial_host.sv
// host model clocking a frame out of the serial port
`timescale 1ns/1ps
module serial_host (
  // serial port
  input  wire  serial_result_out_i,
  output logic sclk_o
);
  initial sclk_o = 1'b0;
  // 8 MHz clock, inside the 16 MHz ceiling
  task automatic read_frame(output logic [15:0] w);
    repeat (16) begin
      #62.5 sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
      w = {w[14:0], serial_result_out_i};
    end
  endtask // clock left parked low
endmodule // serial_host

// >>> testbench/test_adc_convert_serial_readout.sv
// randomised bench for conversion control and serial readout
`timescale 1ns/1ps
module test_adc_convert_serial_readout;
  logic        mclk_i = 0, reset_i = 1, start_n = 1, bipolar = 0;
  logic [13:0] code = 14'h0;
  logic [15:0] w;
  logic [31:0] seed = 10686;
  wire         busy, th, pd, sclk, sd, oe;
  int          mismatches = 0, num_checks = 0, cyc = 0;
  initial forever #2.5 mclk_i = ~mclk_i;
  adc_convert_serial_readout #(.CONV_CYCLES(20), .WAKE_CYCLES(20)) dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .conversion_start_n_i(start_n), .busy_o(busy),
    .track_hold_o(th), .power_down_o(pd), .bipolar_i(bipolar), .sar_code_i(code),
    .serial_clk_i(sclk), .serial_result_out_o(sd), .serial_result_out_oe_o(oe));
  serial_host host (.serial_result_out_i(sd), .sclk_o(sclk));
  function logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // expected frame: two zeros then the code, msb flipped when bipolar
  function logic [15:0] frame(input logic [13:0] c, input logic b);
    return {2'b00, c[13] ^ b, c[12:0]};
  endfunction
  task check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %0t got %h want %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // inputs move a fixed 1 ns after the edge
  task tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // bounded wait, then the busy level is compared
  task wait_busy(input logic v);
    for (int i = 0; i < 200 && busy !== v; i++) tick(1);
    check(16'(busy), 16'(v));
  endtask
  // hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      stop_test;
    end
  end
  initial begin
    tick(6);
    reset_i = 0;
    tick(2);
    for (int n = 0; n < 12; n++) begin
      seed = xs(seed);
      code = (n < 2) ? {14{n[0]}} : seed[13:0]; // zero and full scale first
      bipolar = n[0];
      start_n = 0;
      wait_busy(1'b1);
      check(16'(th), 16'h1);
      if (!n[1]) begin
        tick(2);
        start_n = 1;
        tick(4);
        start_n = 0; // a second start mid-conversion must be ignored
        tick(3);
        start_n = 1;
      end
      wait_busy(1'b0);
      tick(4);
      check(16'(pd), 16'(n[1]));
      host.read_frame(w);
      check(w, frame(code, bipolar));
      tick(10);
      check(16'(oe), 16'h0);
      start_n = 1;
      if (n[1] && n[2]) begin
        tick(5);
        start_n = 0; // narrow pulse: the fall lands inside wake-up
        wait_busy(1'b1);
        tick(2);
        start_n = 1;
        wait_busy(1'b0);
        tick(4);
        host.read_frame(w);
        check(w, frame(code, bipolar));
      end
      tick(40);
      check(16'(pd), 16'h0);
    end
    stop_test;
  end
endmodule // test_adc_convert_serial_readout
bind adc_convert_serial_readout adc_readout_checker #(
  .CONV_CYCLES(CONV_CYCLES), .WAKE_CYCLES(WAKE_CYCLES)) chk (
  .mclk_i(mclk_i), .reset_i(reset_i), .conversion_start_n_i(conversion_start_n_i),
  .busy_o(busy_o), .track_hold_o(track_hold_o), .power_down_o(power_down_o),
  .bipolar_i(bipolar_i), .serial_clk_i(serial_clk_i), .sar_code_i(sar_code_i),
  .serial_result_out_o(serial_result_out_o),
  .serial_result_out_oe_o(serial_result_out_oe_o));
